//--- include/cps_regs.svh
// Timing and count constants for the converter protection sequencer.
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

`define CPS_CLK_PERIOD_PS     4000
`define CPS_US_CYCLES         (1000000 / `CPS_CLK_PERIOD_PS)
`define CPS_FSW_KHZ           120
`define CPS_FMIN_KHZ          15
`define CPS_SKIP_MAX          (`CPS_FSW_KHZ / `CPS_FMIN_KHZ)
`define CPS_SKIP_FLOOR_MS     200
`define CPS_SKIP_FLOOR_US     (`CPS_SKIP_FLOOR_MS * 1000)
`define CPS_RESTART_MS        1000
`define CPS_RESTART_US        (`CPS_RESTART_MS * 1000)
`define CPS_OVL_TRIP_MS       50
`define CPS_OVL_COUNT         (`CPS_OVL_TRIP_MS * `CPS_FSW_KHZ)
`define CPS_DMAX_TRIP_CYCLES  10
`define CPS_SS_MS             8
`define CPS_SS_STEPS          8
`define CPS_SS_STEP_US        (`CPS_SS_MS * 1000 / `CPS_SS_STEPS)
`define CPS_SHUTDOWN_DEB_MS   10
`define CPS_SHUTDOWN_DEB_US   (`CPS_SHUTDOWN_DEB_MS * 1000)
`define CPS_WAKE_DEB_US       20
`define CPS_TON_MIN_NS        400
`define CPS_TON_MIN_CYC       ((`CPS_TON_MIN_NS * 1000 + `CPS_CLK_PERIOD_PS - 1) / `CPS_CLK_PERIOD_PS)

`endif

//--- include/cps_pkg.sv
// Types shared by the converter protection sequencer.
package cps_pkg;

	typedef enum logic [1:0] {
		CPS_RUN     = 2'b00,
		CPS_RESTART = 2'b01,
		CPS_IDLE    = 2'b10
	} cps_state_type;

	typedef struct packed {
		logic idle;
		logic restarting;
		logic light_load;
		logic skip_floor;
	} cps_status_type;

	typedef struct packed {
		logic overcurrent_comparator;
		logic pwm;
		logic max_duty;
	} cps_end_type;

endpackage : cps_pkg

//--- design/cps_debounce.sv
// Pin synchroniser and hold-time debouncer for an active-low request pin.
`timescale 1ns/100ps
`include "cps_regs.svh"

module cps_debounce #(
	parameter logic [13:0] HOLD_US = 14'h0014
) (
	// Clock and reset.
	input  wire logic core_clk_in,
	input  wire logic reset_in,
	// Pin and time base.
	input  wire logic pin_n_in,
	input  wire logic us_tick_in,
	input  wire logic clear_in,
	// Result.
	output logic      held_out
);

	logic        sync1_r;
	logic        sync2_r;
	logic        sync3_r;
	logic        low_r;
	logic [13:0] count_r;
	wire         agree = (sync2_r == sync3_r);
	wire         past  = (count_r > HOLD_US);

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			sync3_r <= 1'b1;
		end else begin
			sync1_r <= pin_n_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			low_r <= 1'b0;
		else if (agree)
			low_r <= ~sync3_r;
	end

	// Any release longer than one clock restarts the count, so the hold must be continuous.
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			count_r <= 14'h0000;
		else if (clear_in || !low_r)
			count_r <= 14'h0000;
		else if (us_tick_in && !past)
			count_r <= count_r + 14'h0001;
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			held_out <= 1'b0;
		else
			held_out <= past && low_r && !clear_in;
	end

endmodule : cps_debounce

//--- design/cps_sequencer.sv
// Cycle-level control and protection sequencer of the off-line converter.
// Notes on behaviour
// - Early current limit skips next cycle, floor-bounded.
// - Clean cycle restores one skipped cycle.
// - Skip floor held too long stops, restarts.
// - Low compensation: demand-driven skipping.
// - Idle: no switching, everything but wake off.
// - Enter idle after shutdown low 10 ms.
// - Leave idle after wake low 20 us.
// - Power-up always starts in normal mode.
// - Overcurrent comparator ends on-time at limit.
// - Overcurrent cycles count up; end-of-count trips.
// - Trip: wait restart interval, soft start.
// - Other cycles count down, floor zero.
// - Restart interval runs to completion unless shutdown is held.
// - Ten consecutive max-duty cycles stop switching.
// - Max-duty trip: restart interval, soft start.
// - Soft start raises limit in eight steps.
`timescale 1ns/100ps
`include "cps_regs.svh"

module cps_sequencer import cps_pkg::*; #(
	parameter logic [19:0] RESTART_US     = 20'(`CPS_RESTART_US),
	parameter logic [19:0] SKIP_FLOOR_US  = 20'(`CPS_SKIP_FLOOR_US),
	parameter logic [12:0] OVL_COUNT      = 13'(`CPS_OVL_COUNT),
	parameter logic [13:0] SHUTDOWN_DEB_US = 14'(`CPS_SHUTDOWN_DEB_US),
	parameter logic [13:0] WAKE_DEB_US    = 14'(`CPS_WAKE_DEB_US),
	parameter logic [9:0]  SS_STEP_US     = 10'(`CPS_SS_STEP_US)
) (
	// Clock and reset.
	input  wire logic     core_clk_in,
	input  wire logic     reset_in,
	// Oscillator and comparators.
	input  wire logic     cycle_tick_in,
	input  wire cps_end_type end_in,
	input  wire logic     comp_low_in,
	input  wire logic     pfm_demand_in,
	// Active-low request pins.
	input  wire logic     shutdown_n_in,
	input  wire logic     wake_n_in,
	// Power stage and status.
	output logic          gate_out,
	output logic [3:0]    peak_limit_step_out,
	output cps_status_type status_out,
	output logic          power_down_out
);

	localparam logic [7:0] US_LAST   = 8'(`CPS_US_CYCLES - 1);
	localparam logic [3:0] SKIP_MAX  = 4'(`CPS_SKIP_MAX);
	localparam logic [7:0] TON_MIN   = 8'(`CPS_TON_MIN_CYC);
	localparam logic [3:0] DMAX_LAST = 4'(`CPS_DMAX_TRIP_CYCLES - 1);
	localparam logic [3:0] SS_TOP    = 4'(`CPS_SS_STEPS);

	cps_state_type state_r;
	cps_state_type state_nxt;
	cps_status_type status_nxt;
	logic [7:0]  us_cnt_r;
	logic        us_tick_r;
	logic [3:0]  skip_div_r;
	logic [3:0]  tick_cnt_r;
	logic        gate_r;
	logic [7:0]  on_cnt_r;
	logic        early_r;
	logic [12:0] ovl_cnt_r;
	logic [3:0]  dmax_cnt_r;
	logic [19:0] timer_r;
	logic [19:0] floor_us_r;
	logic [9:0]  ss_us_r;
	logic [3:0]  ss_step_r;
	logic        light_r;
	logic        shut_held;
	logic        wake_held;

	wire run          = (state_r == CPS_RUN);
	wire min_on_done  = (on_cnt_r == TON_MIN);
	wire end_ocp      = gate_r && min_on_done && (end_in.overcurrent_comparator || early_r);
	wire end_pwm      = gate_r && min_on_done && end_in.pwm && !end_ocp;
	wire end_dmax     = gate_r && end_in.max_duty && !end_ocp && !end_pwm;
	wire cycle_end    = end_ocp || end_pwm || end_dmax;
	wire ovl_trip     = end_ocp && (ovl_cnt_r == OVL_COUNT - 13'h0001);
	wire dmax_trip    = end_dmax && (dmax_cnt_r == DMAX_LAST);
	wire floor_trip   = (floor_us_r == SKIP_FLOOR_US);
	wire trip         = run && (ovl_trip || dmax_trip || floor_trip);
	wire timer_done   = (timer_r == RESTART_US);
	wire enter_run    = (state_nxt == CPS_RUN) && !run;
	wire skip_ok      = (tick_cnt_r >= skip_div_r - 4'h1);
	wire demand_ok    = !light_r || pfm_demand_in;
	wire fire         = run && (state_nxt == CPS_RUN) && cycle_tick_in && !gate_r
	                    && skip_ok && demand_ok;

	// Shutdown is watched outside idle and held clear in idle; wake is watched in idle and held clear elsewhere.
	cps_debounce #(.HOLD_US(SHUTDOWN_DEB_US)) u_shutdown_deb (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.pin_n_in    (shutdown_n_in),
		.us_tick_in  (us_tick_r),
		.clear_in    (state_r == CPS_IDLE),
		.held_out    (shut_held)
	);

	cps_debounce #(.HOLD_US(WAKE_DEB_US)) u_wake_deb (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.pin_n_in    (wake_n_in),
		.us_tick_in  (us_tick_r),
		.clear_in    (state_r != CPS_IDLE),
		.held_out    (wake_held)
	);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			CPS_RUN: begin
				if (shut_held)
					state_nxt = CPS_IDLE;
				else if (trip)
					state_nxt = CPS_RESTART;
			end
			CPS_RESTART: begin
				if (shut_held)
					state_nxt = CPS_IDLE;
				else if (timer_done)
					state_nxt = CPS_RUN;
			end
			CPS_IDLE: begin
				if (wake_held)
					state_nxt = CPS_RUN;
			end
			default: state_nxt = CPS_RUN;
		endcase
	end

	assign status_nxt = '{idle:       state_nxt == CPS_IDLE,
	                      restarting: state_nxt == CPS_RESTART,
	                      light_load: light_r,
	                      skip_floor: skip_div_r == SKIP_MAX};

	// Reset lands in normal mode, so a power loss forgets any idle request.
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			state_r <= CPS_RUN;
		else
			state_r <= state_nxt;
	end

	// The microsecond base runs from the core clock, never from the skipped cycles.
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			us_cnt_r  <= 8'h00;
			us_tick_r <= 1'b0;
		end else begin
			us_cnt_r  <= (us_cnt_r == US_LAST) ? 8'h00 : us_cnt_r + 8'h01;
			us_tick_r <= (us_cnt_r == US_LAST);
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			skip_div_r <= 4'h1;
		else if (!run)
			skip_div_r <= 4'h1;
		else if (cycle_end && early_r && skip_div_r != SKIP_MAX)
			skip_div_r <= skip_div_r + 4'h1;
		else if (cycle_end && !early_r && skip_div_r != 4'h1)
			skip_div_r <= skip_div_r - 4'h1;
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			tick_cnt_r <= 4'h0;
		else if (!run || fire)
			tick_cnt_r <= 4'h0;
		else if (cycle_tick_in && tick_cnt_r != 4'hF)
			tick_cnt_r <= tick_cnt_r + 4'h1;
	end

	// Only a max-duty end can open the switch before the minimum on-time, so an early current hit is held.
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			gate_r   <= 1'b0;
			on_cnt_r <= 8'h00;
			early_r  <= 1'b0;
		end else if (!run || state_nxt != CPS_RUN) begin
			gate_r   <= 1'b0;
			on_cnt_r <= 8'h00;
			early_r  <= 1'b0;
		end else if (fire) begin
			gate_r   <= 1'b1;
			on_cnt_r <= 8'h00;
			early_r  <= 1'b0;
		end else if (gate_r) begin
			gate_r   <= !cycle_end;
			on_cnt_r <= min_on_done ? on_cnt_r : on_cnt_r + 8'h01;
			early_r  <= early_r || (end_in.overcurrent_comparator && !min_on_done);
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			ovl_cnt_r <= 13'h0000;
		else if (!run || trip)
			ovl_cnt_r <= 13'h0000;
		else if (end_ocp)
			ovl_cnt_r <= ovl_cnt_r + 13'h0001;
		else if (cycle_end && ovl_cnt_r != 13'h0000)
			ovl_cnt_r <= ovl_cnt_r - 13'h0001;
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			dmax_cnt_r <= 4'h0;
		else if (!run || trip || end_ocp || end_pwm)
			dmax_cnt_r <= 4'h0;
		else if (end_dmax)
			dmax_cnt_r <= dmax_cnt_r + 4'h1;
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			floor_us_r <= 20'h00000;
		else if (!run || skip_div_r != SKIP_MAX || trip)
			floor_us_r <= 20'h00000;
		else if (us_tick_r)
			floor_us_r <= floor_us_r + 20'h00001;
	end

	// The restart wait ignores the fault inputs entirely once started.
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in)
			timer_r <= 20'h00000;
		else if (state_r != CPS_RESTART)
			timer_r <= 20'h00000;
		else if (us_tick_r && !timer_done)
			timer_r <= timer_r + 20'h00001;
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ss_us_r   <= 10'h000;
			ss_step_r <= 4'h0;
		end else if (enter_run || !run) begin
			ss_us_r   <= 10'h000;
			ss_step_r <= 4'h0;
		end else if (us_tick_r && ss_step_r != SS_TOP) begin
			ss_us_r   <= (ss_us_r == SS_STEP_US - 10'h001) ? 10'h000 : ss_us_r + 10'h001;
			ss_step_r <= (ss_us_r == SS_STEP_US - 10'h001) ? ss_step_r + 4'h1 : ss_step_r;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			light_r        <= 1'b0;
			status_out     <= '0;
			power_down_out <= 1'b0;
		end else begin
			light_r        <= run && comp_low_in;
			status_out     <= status_nxt;
			power_down_out <= (state_nxt == CPS_IDLE);
		end
	end

	assign gate_out            = gate_r;
	assign peak_limit_step_out = ss_step_r;

	a_idle_no_gate: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_r == CPS_IDLE) |-> (!gate_out && power_down_out))
		else $error("gate active or powered while idle");
	a_skip_up: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(run && state_nxt == CPS_RUN && cycle_end && early_r && skip_div_r < SKIP_MAX)
		|=> (skip_div_r == $past(skip_div_r) + 4'h1))
		else $error("skip ratio did not rise after early limit");
	a_skip_down: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(run && state_nxt == CPS_RUN && cycle_end && !early_r && skip_div_r > 4'h1)
		|=> (skip_div_r == $past(skip_div_r) - 4'h1))
		else $error("skip ratio did not fall after clean cycle");
	a_skip_range: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(skip_div_r >= 4'h1) && (skip_div_r <= SKIP_MAX))
		else $error("skip ratio out of range");
	a_ocp_ends: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(gate_r && min_on_done && end_in.overcurrent_comparator) |=> !gate_r)
		else $error("gate stayed on after current limit");
	a_ovl_trip: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(run && !shut_held && end_ocp && ovl_cnt_r == OVL_COUNT - 13'h0001)
		|=> (state_r == CPS_RESTART))
		else $error("overload end-of-count did not trip");
	a_ovl_down: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(run && !trip && state_nxt == CPS_RUN && end_pwm && ovl_cnt_r != 13'h0000)
		|=> (ovl_cnt_r == $past(ovl_cnt_r) - 13'h0001))
		else $error("overload count did not fall");
	a_dmax_trip: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(run && !shut_held && end_dmax && dmax_cnt_r == DMAX_LAST) |=> (state_r == CPS_RESTART))
		else $error("tenth max-duty cycle did not trip");
	a_dmax_clear: assert property (@(posedge core_clk_in) disable iff (reset_in)
		end_pwm |=> (dmax_cnt_r == 4'h0))
		else $error("max-duty count not cleared");
	a_restart_hold: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_r == CPS_RESTART && !timer_done && !shut_held) |=> (state_r == CPS_RESTART))
		else $error("restart left before interval expired");
	a_soft_start: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(!run ##1 run) |-> (ss_step_r == 4'h0))
		else $error("soft start did not begin at zero");
	a_wake_exit: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(state_r == CPS_IDLE && wake_held) |=> (state_r == CPS_RUN))
		else $error("wake request did not leave idle");

	c_overload_trip: cover property (@(posedge core_clk_in) disable iff (reset_in) run && ovl_trip);
	c_dmax_trip:     cover property (@(posedge core_clk_in) disable iff (reset_in) run && dmax_trip);
	c_enter_idle:    cover property (@(posedge core_clk_in) disable iff (reset_in)
		run ##1 state_r == CPS_IDLE);
	c_skip_floor:    cover property (@(posedge core_clk_in) disable iff (reset_in)
		skip_div_r == SKIP_MAX);

endmodule : cps_sequencer

//--- sim/cps_pin_partner.sv
// Behavioural controller that pulls the active-low request pins.
`timescale 1ns/100ps

module cps_pin_partner (
	// Clock.
	input  wire logic core_clk_in,
	// Request pins, pulled up while released.
	output logic      shutdown_n_out,
	output logic      wake_n_out
);
	initial begin
		shutdown_n_out = 1'b1;
		wake_n_out     = 1'b1;
	end

	// The pins have pull-ups, so a released pin returns high rather than floating.
	task automatic press(input bit wake, input int us);
		@(posedge core_clk_in);
		#1;
		if (wake) begin
			wake_n_out = 1'b0;
		end else begin
			shutdown_n_out = 1'b0;
		end
		repeat (us * 250) @(posedge core_clk_in);
		#1;
		wake_n_out     = 1'b1;
		shutdown_n_out = 1'b1;
	endtask : press
endmodule : cps_pin_partner

//--- sim/test_cps_sequencer.sv
// Self-checking bench for the converter protection sequencer.
`timescale 1ns/100ps
`include "cps_regs.svh"

module test_cps_sequencer import cps_pkg::*; ;
	localparam int US = 250;
	logic           core_clk_in = 1'b0;
	logic           reset_in    = 1'b1;
	logic           tick        = 1'b0;
	cps_end_type    ends        = '0;
	logic           comp_low    = 1'b0;
	logic           pfm_dem     = 1'b0;
	logic           shutdown_n;
	logic           wake_n;
	logic           gate;
	logic           pd;
	logic [3:0]     step;
	cps_status_type st;
	int             error_cnt   = 0;
	int             checks_done = 0;
	int             width       = 0;
	int             n;
	int             exp_q[$];
	logic [31:0]    rnd         = 32'h0000D5B0;

	always #2 core_clk_in = ~core_clk_in;

	cps_sequencer #(
		.RESTART_US     (20'h00032),
		.SKIP_FLOOR_US  (20'h00028),
		.OVL_COUNT      (13'h0008),
		.SHUTDOWN_DEB_US(14'h001E),
		.SS_STEP_US     (10'h004)
	) dut (
		.core_clk_in        (core_clk_in),
		.reset_in           (reset_in),
		.cycle_tick_in      (tick),
		.end_in             (ends),
		.comp_low_in        (comp_low),
		.pfm_demand_in      (pfm_dem),
		.shutdown_n_in      (shutdown_n),
		.wake_n_in          (wake_n),
		.gate_out           (gate),
		.peak_limit_step_out(step),
		.status_out         (st),
		.power_down_out     (pd)
	);

	cps_pin_partner partner (
		.core_clk_in   (core_clk_in),
		.shutdown_n_out(shutdown_n),
		.wake_n_out    (wake_n)
	);

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
		end
	endtask : chk

	task automatic nxt(input int c);
		repeat (c) @(posedge core_clk_in);
		#1;
	endtask : nxt

	task automatic end_sim();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic do_reset();
		reset_in = 1'b1;
		ends     = '0;
		comp_low = 1'b0;
		pfm_dem  = 1'b0;
		nxt(6);
		reset_in = 1'b0;
	endtask : do_reset

	// Ticks with random spacing until the switch fires; kind 0 pwm, 1 ocp, 2 max duty.
	task automatic run_cycle(input int kind, output int cnt);
		int m;
		cnt = 0;
		m   = 0;
		while (gate !== 1'b1 && cnt < 12) begin
			tick = 1'b1;
			cnt++;
			nxt(1);
			tick = 1'b0;
			if (gate !== 1'b1) begin
				rnd = xs(rnd);
				nxt(1 + int'(rnd[2:0]));
			end
		end
		// The end is driven just after the gate rises, so a max-duty cycle lasts one clock.
		// A limited cycle lasts the minimum on-time plus the clock that registers its end.
		if (gate === 1'b1) begin
			exp_q.push_back(kind == 2 ? 0 : `CPS_TON_MIN_CYC + 1);
			ends = cps_end_type'(kind == 1 ? 3'b100 : kind == 0 ? 3'b010 : 3'b001);
			while (gate === 1'b1 && m < 300) begin
				m++;
				nxt(1);
			end
			ends = '0;
		end
	endtask : run_cycle

	// Waits for a trip, then follows the restart interval to its end.
	task automatic expect_restart(input int lim);
		int w;
		w = 0;
		while (st.restarting !== 1'b1 && w < lim) begin
			w++;
			nxt(1);
		end
		chk({st.restarting, gate}, 2'b10, "trip");
		run_cycle(2, n);
		chk(n, 12, "restart ignores ticks");
		nxt(45 * US);
		chk(st.restarting, 1, "restart too short");
		nxt(7 * US);
		chk({st.restarting, step}, 5'h00, "restart end");
		run_cycle(0, n);
		chk(n, 1, "skip ratio after trip");
	endtask : expect_restart

	// Gate widths are compared with the oldest note of the driver.
	// Sampling on the falling edge keeps the count clear of the launching edge.
	always @(negedge core_clk_in) begin
		if (gate === 1'b1) begin
			width++;
		end else if (width != 0) begin
			if (exp_q.size() == 0) begin
				chk(0, 1, "unexpected switching cycle");
			end else if (exp_q[0] == 0) begin
				chk(width, 1, "max duty width");
				void'(exp_q.pop_front());
			end else begin
				chk(width, exp_q.pop_front(), "on-time width");
			end
			width = 0;
		end
	end

	initial begin
		repeat (390 * US) @(posedge core_clk_in);
		error_cnt++;
		end_sim();
	end

	initial begin
		do_reset();
		chk({gate, step, st, pd}, 10'h000, "reset state");
		nxt(30 * US);
		chk(step, 7, "soft start step");
		nxt(4 * US);
		chk(step, 8, "soft start end");
		for (int k = 1; k <= 7; k++) begin
			run_cycle(1, n);
			chk(n, k, "skip on early limit");
		end
		for (int k = 8; k >= 2; k--) begin
			run_cycle(0, n);
			chk(n, k, "restore skipped cycle");
		end
		for (int k = 1; k <= 7; k++) begin
			run_cycle(1, n);
		end
		chk(st.restarting, 0, "count decremented");
		nxt(38 * US);
		chk(st.restarting, 0, "floor timeout early");
		chk(st.skip_floor, 1, "skip floor flag");
		expect_restart(4 * US);
		do_reset();
		for (int k = 1; k <= 8; k++) begin
			chk(st.restarting, 0, "overload early");
			run_cycle(1, n);
		end
		expect_restart(5);
		do_reset();
		for (int k = 0; k < 19; k++) begin
			run_cycle(k == 9 ? 0 : 2, n);
		end
		chk(st.restarting, 0, "max duty run broken");
		run_cycle(2, n);
		expect_restart(5);
		comp_low = 1'b1;
		nxt(4);
		chk(st.light_load, 1, "light load entry");
		run_cycle(0, n);
		chk(n, 12, "no demand no cycle");
		pfm_dem = 1'b1;
		run_cycle(0, n);
		chk(n, 1, "demand gives cycle");
		comp_low = 1'b0;
		nxt(4);
		chk(st.light_load, 0, "light load exit");
		partner.press(1'b0, 20);
		nxt(8);
		chk(pd, 0, "short shutdown");
		partner.press(1'b0, 34);
		chk({st.idle, pd, gate}, 3'b110, "idle entry");
		run_cycle(0, n);
		chk(n, 12, "idle ignores ticks");
		partner.press(1'b1, 8);
		nxt(8);
		chk(pd, 1, "short wake");
		partner.press(1'b1, 24);
		nxt(8);
		chk({st.idle, pd}, 2'b00, "wake exit");
		partner.press(1'b0, 34);
		do_reset();
		nxt(4);
		chk({st.idle, pd}, 2'b00, "power loss in idle");
		end_sim();
	end
endmodule : test_cps_sequencer
